// ### tm2_defs.svh
// Constants for the timer control block: offsets, bit positions, reset values and timing counts.
// Overview of operation
// - High overflow flag sets on high byte wrap.
// - High flag requests interrupt; never auto-cleared.
// - Low flag sets on every low byte wrap.
// - Low enable lets low wraps interrupt.
// - Comparator rising edge copies count into reload.
// - Every capture event requests timer interrupt.
// - Split bit picks one 16-bit or two 8-bit.
// - Run bit gates counting; split low byte free-runs.
// - Control bit one reads zero, ignores writes.
// - External select picks clock/12 or oscillator/8.
// - Oscillator/8 is synchronised to system clock.
// - Per-byte clock selects override the source choice.
// - 16-bit wrap loads the 16-bit reload value.
// - Split bytes reload from their own bytes.
// - Capture only with enable set, split clear.
`ifndef TM2_DEFS_SVH
`define TM2_DEFS_SVH
`define TM2_ADDR_CTRL 8'hC8
`define TM2_ADDR_RELOAD_LO 8'hCA
`define TM2_ADDR_RELOAD_HI 8'hCB
`define TM2_ADDR_COUNT_LO 8'hCC
`define TM2_ADDR_COUNT_HI 8'hCD
`define TM2_BIT_HOVF 7
`define TM2_BIT_LOVF 6
`define TM2_BIT_LIEN 5
`define TM2_BIT_CAPEN 4
`define TM2_BIT_SPLIT 3
`define TM2_BIT_RUN 2
`define TM2_BIT_UNUSED 1
`define TM2_BIT_XCLK 0
`define TM2_CTRL_RESET 8'h00
`define TM2_BYTE_RESET 8'h00
`define TM2_CTRL_WMASK 8'hFD
`define TM2_SYS_DIV 4'hB
`define TM2_SYNC_STAGES 2
`endif

// ### tm2_pkg.sv
// Types shared by the timer control block files.
package tm2_pkg;
	// Clock source chosen for one count byte.
	typedef enum logic [2:0] {
		TM2_SRC_SYS = 3'b001,
		TM2_SRC_DIV12 = 3'b010,
		TM2_SRC_EXT8 = 3'b100
	} tm2_src_t;
endpackage : tm2_pkg

// ### tm2_tick_if.sv
// Interface carrying the per-byte count ticks from the tick generator to the timer core.
interface tm2_tick_if;
	logic xclk_sel;
	logic high_sys_sel;
	logic low_sys_sel;
	logic high_tick;
	logic low_tick;
	modport gen (input xclk_sel, input high_sys_sel, input low_sys_sel,
		output high_tick, output low_tick);
	modport core (output xclk_sel, output high_sys_sel, output low_sys_sel,
		input high_tick, input low_tick);
endinterface : tm2_tick_if

// ### tm2_tick_gen.sv
// Tick generator: divide-by-12 prescaler, synchronised oscillator/8 edges and per-byte selection.
`include "tm2_defs.svh"
module tm2_tick_gen (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ext_div8,
	tm2_tick_if.gen tk
);
	import tm2_pkg::*;

	logic [3:0] presc_r; // Divide-by-12 counter.
	logic div12_tick; // One-cycle pulse every twelfth clock.
	logic sync1_r; // First synchroniser stage, read only by the second.
	logic sync2_r; // Second synchroniser stage.
	logic sync3_r; // Delayed copy used for edge detection.
	logic ext_tick; // Rising edge of the synchronised oscillator/8.
	tm2_src_t high_src;
	tm2_src_t low_src;

	// Picks the source for one byte; the per-byte select wins over the external select.
	function automatic tm2_src_t pick_src(input logic sys_sel, input logic xsel);
		if (sys_sel) begin
			pick_src = TM2_SRC_SYS;
		end else if (xsel) begin
			pick_src = TM2_SRC_EXT8;
		end else begin
			pick_src = TM2_SRC_DIV12;
		end
	endfunction : pick_src

	// Turns a source choice into a tick for this cycle.
	function automatic logic src_tick(input tm2_src_t s, input logic d12, input logic e8);
		case (s)
			TM2_SRC_SYS: src_tick = 1'b1;
			TM2_SRC_DIV12: src_tick = d12;
			TM2_SRC_EXT8: src_tick = e8;
			default: src_tick = 1'b0;
		endcase
	endfunction : src_tick

	// Prescaler wraps at eleven so it pulses once in twelve clocks.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			presc_r <= 4'h0;
		end else if (presc_r == `TM2_SYS_DIV) begin
			presc_r <= 4'h0;
		end else begin
			presc_r <= presc_r + 4'h1;
		end
	end
	assign div12_tick = (presc_r == `TM2_SYS_DIV);

	// The oscillator clock is asynchronous, so it passes two flops before any edge logic.
	// Suspend mode bypass is not modelled; this block always runs from the system clock.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= i_ext_div8;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign ext_tick = sync2_r & ~sync3_r;

	// Independent choice for each byte.
	always_comb begin
		high_src = pick_src(tk.high_sys_sel, tk.xclk_sel);
		low_src = pick_src(tk.low_sys_sel, tk.xclk_sel);
		tk.high_tick = src_tick(high_src, div12_tick, ext_tick);
		tk.low_tick = src_tick(low_src, div12_tick, ext_tick);
	end
endmodule : tm2_tick_gen

// ### tm2_timer.sv
// Timer top: control register, counting bytes, reload bytes, capture and interrupt request.
`include "tm2_defs.svh"
module tm2_timer (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_sfr_addr, // Special function register address.
	input wire logic i_sfr_wr, // Byte write strobe.
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_bit_wr, // Single-bit write strobe for the control register.
	input wire logic [2:0] i_bit_sel, // Bit number for a bit write.
	input wire logic i_bit_val,
	input wire logic i_timer_irq_en, // Global timer interrupt enable, held elsewhere.
	input wire logic i_high_byte_clock_select,
	input wire logic i_low_byte_clock_select,
	input wire logic i_ext_div8, // External oscillator divided by eight.
	input wire logic i_analog_comparator, // Comparator output, synchronous to the clock.
	output logic [7:0] o_sfr_rdata,
	output logic o_timer_irq
);
	import tm2_pkg::*;

	logic [7:0] ctrl_r; // Control register image, bit one always zero.
	logic [7:0] count_low_byte_r;
	logic [7:0] count_high_byte_r;
	logic [7:0] reload_low_byte_r;
	logic [7:0] reload_high_byte_r;
	logic cmp_d_r; // Previous comparator level.
	logic [7:0] ctrl_nxt; // Control after a software write, before hardware sets.
	logic ctrl_wr_byte;
	logic low_run; // Low byte counts this cycle.
	logic high_run; // High byte counts this cycle.
	logic low_wrap; // Low byte rolls from 0xFF.
	logic high_wrap; // High byte rolls from 0xFF.
	logic capture; // Qualified comparator capture event.
	logic split;
	logic [7:0] rd_mux;

	tm2_tick_if tk();

	// Tick generator owns the clock source selection.
	tm2_tick_gen u_tick (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_ext_div8(i_ext_div8),
		.tk(tk.gen)
	);

	assign tk.xclk_sel = ctrl_r[`TM2_BIT_XCLK];
	assign tk.high_sys_sel = i_high_byte_clock_select;
	assign tk.low_sys_sel = i_low_byte_clock_select;

	// Detects a match with a register address and a byte write.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a, input logic w);
		hit = w && (a == ref_a);
	endfunction : hit

	assign split = ctrl_r[`TM2_BIT_SPLIT];
	assign ctrl_wr_byte = hit(i_sfr_addr, `TM2_ADDR_CTRL, i_sfr_wr);

	// Run gating: in split mode the low byte never stops.
	always_comb begin
		if (split) begin
			low_run = tk.low_tick;
			high_run = tk.high_tick & ctrl_r[`TM2_BIT_RUN];
		end else begin
			// In 16-bit mode the whole counter follows the low byte's clock choice.
			low_run = tk.low_tick & ctrl_r[`TM2_BIT_RUN];
			high_run = low_run & (count_low_byte_r == 8'hFF);
		end
		low_wrap = low_run & (count_low_byte_r == 8'hFF);
		high_wrap = high_run & (count_high_byte_r == 8'hFF);
	end

	// Capture needs the enable and 16-bit mode.
	assign capture = ctrl_r[`TM2_BIT_CAPEN] & ~split & i_analog_comparator & ~cmp_d_r;

	// Comparator edge detector.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cmp_d_r <= 1'b0;
		end else begin
			cmp_d_r <= i_analog_comparator;
		end
	end

	// Software image of the control register: byte write or single-bit write.
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr_byte) begin
			ctrl_nxt = i_sfr_wdata & `TM2_CTRL_WMASK;
		end else if (i_bit_wr && (i_sfr_addr == `TM2_ADDR_CTRL)) begin
			ctrl_nxt[i_bit_sel] = i_bit_val;
			ctrl_nxt[`TM2_BIT_UNUSED] = 1'b0;
		end
	end

	// Control register. Hardware only ever sets flags; a flag write of one wins anyway,
	// and a write of zero in the same cycle as an event loses so no overflow is missed.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_r <= `TM2_CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (high_wrap || capture) begin
				ctrl_r[`TM2_BIT_HOVF] <= 1'b1;
			end
			if (low_wrap) begin
				ctrl_r[`TM2_BIT_LOVF] <= 1'b1;
			end
		end
	end

	// Low count byte: software write first, else reload on split-mode wrap or full 16-bit wrap, else increment.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_low_byte_r <= `TM2_BYTE_RESET;
		end else if (hit(i_sfr_addr, `TM2_ADDR_COUNT_LO, i_sfr_wr)) begin
			count_low_byte_r <= i_sfr_wdata;
		end else if (low_wrap && split) begin
			count_low_byte_r <= reload_low_byte_r;
		end else if (low_wrap && high_wrap) begin
			count_low_byte_r <= reload_low_byte_r;
		end else if (low_run) begin
			count_low_byte_r <= count_low_byte_r + 8'h01;
		end
	end

	// High count byte, same priority order.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_high_byte_r <= `TM2_BYTE_RESET;
		end else if (hit(i_sfr_addr, `TM2_ADDR_COUNT_HI, i_sfr_wr)) begin
			count_high_byte_r <= i_sfr_wdata;
		end else if (high_wrap) begin
			count_high_byte_r <= reload_high_byte_r;
		end else if (high_run) begin
			count_high_byte_r <= count_high_byte_r + 8'h01;
		end
	end

	// Reload bytes. Capture beats a software write so the measurement is never lost.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reload_low_byte_r <= `TM2_BYTE_RESET;
			reload_high_byte_r <= `TM2_BYTE_RESET;
		end else if (capture) begin
			reload_low_byte_r <= count_low_byte_r;
			reload_high_byte_r <= count_high_byte_r;
		end else begin
			if (hit(i_sfr_addr, `TM2_ADDR_RELOAD_LO, i_sfr_wr)) begin
				reload_low_byte_r <= i_sfr_wdata;
			end
			if (hit(i_sfr_addr, `TM2_ADDR_RELOAD_HI, i_sfr_wr)) begin
				reload_high_byte_r <= i_sfr_wdata;
			end
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		case (i_sfr_addr)
			`TM2_ADDR_CTRL: rd_mux = ctrl_r;
			`TM2_ADDR_RELOAD_LO: rd_mux = reload_low_byte_r;
			`TM2_ADDR_RELOAD_HI: rd_mux = reload_high_byte_r;
			`TM2_ADDR_COUNT_LO: rd_mux = count_low_byte_r;
			`TM2_ADDR_COUNT_HI: rd_mux = count_high_byte_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// Registered outputs: read data and interrupt appear one cycle after their cause.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sfr_rdata <= 8'h00;
			o_timer_irq <= 1'b0;
		end else begin
			o_sfr_rdata <= rd_mux;
			o_timer_irq <= i_timer_irq_en & (ctrl_r[`TM2_BIT_HOVF] |
				(ctrl_r[`TM2_BIT_LOVF] & ctrl_r[`TM2_BIT_LIEN]));
		end
	end
endmodule : tm2_timer

// ### tm2_cpu_model.sv
// CPU side model that drives the register bus of the timer.
module tm2_cpu_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_bit_wr,
	output logic [2:0] o_bit_sel,
	output logic o_bit_val
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet bus from time zero.
	initial {o_addr, o_wr, o_wdata, o_bit_wr, o_bit_sel, o_bit_val} = '0;
	// Byte write; data is scrambled after the strobe so stale data cannot pass.
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_sys_clk) {o_addr, o_wr, o_wdata} = {a, 1'b1, v};
		@(negedge i_sys_clk) {o_wr, o_wdata} = {1'b0, ~v};
	endtask : wr
	// Single-bit write to the control register.
	task bw(input logic [2:0] s, input logic v);
		@(negedge i_sys_clk) {o_addr, o_bit_wr, o_bit_sel, o_bit_val} = {8'hC8, 1'b1, s, v};
		@(negedge i_sys_clk) {o_bit_wr, o_bit_val} = {1'b0, ~v};
	endtask : bw
	// Read data is registered, so it is taken one edge after the address.
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge i_sys_clk) o_addr = a;
		@(negedge i_sys_clk) v = i_rdata;
	endtask : rd
endmodule : tm2_cpu_model

// ### tm2_timer_assertions.sv
// Concurrent checks on the ports of the timer control block.
module tm2_timer_assertions (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_bit_wr,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_bit_val,
	input wire logic i_timer_irq_en,
	input wire logic i_high_byte_clock_select,
	input wire logic i_low_byte_clock_select,
	input wire logic i_ext_div8,
	input wire logic i_analog_comparator,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_timer_irq
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	// A control write shows on the next readback; flags are left out as hardware may set them.
	ctrl_write_a: assert property (
		i_sfr_wr && i_sfr_addr == 8'hC8 ##1 i_sfr_addr == 8'hC8
		|=> {o_sfr_rdata[5:2], o_sfr_rdata[0]} == $past({i_sfr_wdata[5:2], i_sfr_wdata[0]}, 2))
		else $error("control write not seen");
	// A reload write with no comparator edge is read back whole.
	reload_write_a: assert property (
		i_sfr_wr && i_sfr_addr == 8'hCA && !i_analog_comparator ##1 i_sfr_addr == 8'hCA
		|=> o_sfr_rdata == $past(i_sfr_wdata, 2))
		else $error("reload write not seen");
	// Bit write of the run bit.
	bit_write_a: assert property (
		i_bit_wr && !i_sfr_wr && i_sfr_addr == 8'hC8 && i_bit_sel == 3'h2 ##1 i_sfr_addr == 8'hC8
		|=> o_sfr_rdata[2] == $past(i_bit_val, 2))
		else $error("bit write not seen");
	unused_zero_a: assert property ($past(i_sfr_addr) == 8'hC8 |-> !o_sfr_rdata[1])
		else $error("unused bit read as one");
	unmapped_zero_a: assert property (
		!($past(i_sfr_addr) inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD}) |-> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	// Without a write, a set flag must still be set one cycle on.
	flags_hold_a: assert property (
		$past(i_sfr_addr == 8'hC8 && !i_sfr_wr && !i_bit_wr) && i_sfr_addr == 8'hC8
		|=> (o_sfr_rdata[7:6] & $past(o_sfr_rdata[7:6])) == $past(o_sfr_rdata[7:6]))
		else $error("flag cleared by hardware");
	// Request level agrees with the flags shown in the same cycle.
	irq_level_a: assert property ($past(i_sfr_addr) == 8'hC8 |-> o_timer_irq ==
		($past(i_timer_irq_en) && (o_sfr_rdata[7] || o_sfr_rdata[6] && o_sfr_rdata[5])))
		else $error("interrupt level wrong");
	irq_gate_a: assert property (o_timer_irq |-> $past(i_timer_irq_en))
		else $error("interrupt without enable");
	cover property (o_timer_irq);
	cover property ($rose(i_analog_comparator));
	cover property (i_bit_wr && i_bit_sel == 3'h1);
endmodule : tm2_timer_assertions
bind tm2_timer tm2_timer_assertions u_chk (.*);

// ### tm2_timer_tb.sv
// Self-checking testbench for the timer control block.
module tm2_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_timer_irq_en = 1'b0;
	logic i_high_byte_clock_select = 1'b1;
	logic i_low_byte_clock_select = 1'b1;
	logic i_ext_div8 = 1'b0;
	logic i_analog_comparator = 1'b0;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, d;
	logic [2:0] i_bit_sel;
	logic i_sfr_wr, i_bit_wr, i_bit_val, o_timer_irq;
	logic [7:0] adr [6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
	int err_total = 0;
	int num_checks = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	tm2_timer DUT (.*);
	tm2_cpu_model CPU (.i_sys_clk, .i_rdata(o_sfr_rdata), .o_addr(i_sfr_addr), .o_wr(i_sfr_wr),
		.o_wdata(i_sfr_wdata), .o_bit_wr(i_bit_wr), .o_bit_sel(i_bit_sel), .o_bit_val(i_bit_val));
	// Counted comparison.
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task rc(input logic [7:0] a, input logic [7:0] exp);
		CPU.rd(a, d);
		chk(d, exp);
	endtask : rc
	// Bounded wait for a control flag; running out ends the run.
	task poll(input int b);
		for (int n = 0; n < 400; n++) begin
			CPU.rd(8'hC8, d);
			if (d[b] === 1'b1) return;
		end
		err_total++;
		$display("[ERR] %0t flag wait ran out", $time);
		tally_and_finish();
	endtask : poll
	task t_regs;
		foreach (adr[i]) rc(adr[i], 8'h00);
		CPU.wr(8'hC8, 8'hFF);
		rc(8'hC8, 8'hFD);
		CPU.bw(3'h1, 1'b1);
		rc(8'hC8, 8'hFD);
		CPU.wr(8'hC8, 8'h00);
		rc(8'hC8, 8'h00);
	endtask : t_regs
	// Full 16-bit wrap reloads the high byte and the stopped low byte holds; then the request gating is walked.
	task t_wrap;
		CPU.wr(8'hCB, 8'h12);
		CPU.wr(8'hCA, 8'h34);
		CPU.wr(8'hCD, 8'hFF);
		CPU.wr(8'hCC, 8'hF0);
		CPU.wr(8'hC8, 8'h04);
		poll(7);
		CPU.bw(3'h2, 1'b0);
		rc(8'hC8, 8'hC0);
		rc(8'hCD, 8'h12);
		CPU.rd(8'hCC, d);
		rc(8'hCC, d);
		rc(8'hC8, 8'hC0);
		i_timer_irq_en = 1'b1;
		CPU.bw(3'h7, 1'b0);
		rc(8'hC8, 8'h40);
		chk({7'h0, o_timer_irq}, 8'h00);
		CPU.bw(3'h5, 1'b1);
		rc(8'hC8, 8'h60);
		chk({7'h0, o_timer_irq}, 8'h01);
		i_timer_irq_en = 1'b0;
		rc(8'hC8, 8'h60);
		chk({7'h0, o_timer_irq}, 8'h00);
	endtask : t_wrap
	// Split mode: low byte free-runs, high byte waits for the run bit.
	task t_split;
		CPU.wr(8'hCA, 8'hF0);
		rc(8'hCA, 8'hF0);
		CPU.wr(8'hCB, 8'hA0);
		CPU.wr(8'hCD, 8'hFE);
		CPU.wr(8'hCC, 8'hFE);
		CPU.wr(8'hC8, 8'h08);
		poll(6);
		rc(8'hCD, 8'hFE);
		CPU.rd(8'hCC, d);
		chk({7'h0, d >= 8'hF0}, 8'h01);
		CPU.wr(8'hC8, 8'h0C);
		poll(7);
		CPU.rd(8'hCD, d);
		chk({7'h0, d >= 8'hA0}, 8'h01);
		CPU.wr(8'hC8, 8'h00);
	endtask : t_split
	// Capture with the count frozen, then a refused capture in split mode.
	task t_capture;
		i_timer_irq_en = 1'b1;
		CPU.wr(8'hCD, 8'hAB);
		CPU.wr(8'hCC, 8'hCD);
		CPU.wr(8'hC8, 8'h10);
		i_analog_comparator = 1'b1;
		rc(8'hCB, 8'hAB);
		rc(8'hCA, 8'hCD);
		rc(8'hC8, 8'h90);
		chk({7'h0, o_timer_irq}, 8'h01);
		i_analog_comparator = 1'b0;
		CPU.wr(8'hC8, 8'h18);
		CPU.wr(8'hCC, 8'h11);
		i_analog_comparator = 1'b1;
		rc(8'hCA, 8'hCD);
		i_analog_comparator = 1'b0;
	endtask : t_capture
	// Six oscillator edges must give exactly three counts.
	task t_ext;
		CPU.wr(8'hC8, 8'h00);
		CPU.wr(8'hCC, 8'h00);
		i_low_byte_clock_select = 1'b0;
		CPU.wr(8'hC8, 8'h05);
		repeat (6) begin
			repeat (4) @(negedge i_sys_clk);
			i_ext_div8 = ~i_ext_div8;
		end
		repeat (6) @(negedge i_sys_clk);
		CPU.bw(3'h2, 1'b0);
		rc(8'hCC, 8'h03);
	endtask : t_ext
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(negedge i_sys_clk);
		i_rst_b = 1'b1;
		t_regs();
		t_wrap();
		t_split();
		t_capture();
		t_ext();
		tally_and_finish();
	end
endmodule : tm2_timer_tb
